// ### verilog/gsec_map.vh
// constants for the global shutter exposure control block
`ifndef GSEC_MAP_VH
`define GSEC_MAP_VH

// ************************************************************
// register offsets
// ************************************************************
`define GSEC_ADDR_W 4
`define GSEC_OFS_COL_START 4'h0
`define GSEC_OFS_COL_LAST 4'h4
`define GSEC_OFS_STATUS 4'h8
`define GSEC_OFS_INT_TIME 4'hC

// ************************************************************
// field layout
// ************************************************************
`define GSEC_COL_W 7
`define GSEC_CNT_W 24
`define GSEC_ST_INTEGRATING 0
`define GSEC_ST_STORED 1
`define GSEC_ST_DS_SEEN 2
`define GSEC_ST_FULL_RESET 3
`define GSEC_ST_STANDBY 4
`define GSEC_ST_BLACK 5
`define GSEC_ST_COL_LSB 8

// ************************************************************
// reset values and counter saturation limit
// ************************************************************
`define GSEC_RST_COL_START 7'h00
`define GSEC_RST_COL_LAST 7'h4F
`define GSEC_CNT_MAX 24'hFFFFFF

`endif

// ### verilog/gsec_sync.v
// two flip-flop synchroniser for asynchronous control pins
`timescale 1ns/1ps
module gsec_sync #(
    parameter W = 1
) (
    input wire clk_in,
    input wire rstn_in,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ### verilog/gsec_top.v
// exposure, pixel memory and output stage control of a global shutter sensor
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "gsec_map.vh"
module gsec_top (
    input wire clk_in,
    input wire rstn_in,
    input wire reset_pulse_in,
    input wire dual_slope_reset_pulse_in,
    input wire precharge_in,
    input wire sample_in,
    input wire memory_level_select_in,
    input wire black_test_in,
    input wire output_enable_n_in,
    input wire column_shift_clk_in,
    input wire column_sync_in,
    input wire [`GSEC_ADDR_W-1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    output reg pixel_reset_full_out,
    output reg pixel_reset_second_out,
    output reg integrating_out,
    output reg precharge_drive_out,
    output reg sample_drive_out,
    output reg memory_boost_high_out,
    output reg memory_stored_out,
    output reg readout_ready_out,
    output reg black_test_en_out,
    output reg output_stage_active_out,
    output reg [`GSEC_COL_W-1:0] column_addr_out,
    output reg pixel_update_out,
    output reg end_of_line_out
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    wire [8:0] pins_s;
    wire rst_s;
    wire ds_s;
    wire pre_s;
    wire smp_s;
    wire mem_s;
    wire blk_s;
    wire oen_s;
    wire cclk_s;
    wire csync_s;

    // standby pin enters inverted, so a cleared synchroniser reads as standby
    gsec_sync #(
        .W(9)
    ) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .async_in({column_sync_in, column_shift_clk_in, ~output_enable_n_in, black_test_in,
                   memory_level_select_in, sample_in, precharge_in, dual_slope_reset_pulse_in,
                   reset_pulse_in}),
        .sync_out(pins_s)
    );

    assign rst_s = pins_s[0];
    assign ds_s = pins_s[1];
    assign pre_s = pins_s[2];
    assign smp_s = pins_s[3];
    assign mem_s = pins_s[4];
    assign blk_s = pins_s[5];
    assign oen_s = ~pins_s[6];
    assign cclk_s = pins_s[7];
    assign csync_s = pins_s[8];

    // ************************************************************
    // edge history
    // ************************************************************
    reg rst_prev_q;
    reg smp_prev_q;
    reg cclk_prev_q;
    wire rst_rise;
    wire rst_fall;
    wire smp_fall;
    wire cclk_rise;

    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_prev_q <= 1'b0;
            smp_prev_q <= 1'b0;
            cclk_prev_q <= 1'b0;
        end
        else
        begin
            rst_prev_q <= rst_s;
            smp_prev_q <= smp_s;
            cclk_prev_q <= cclk_s;
        end
    end

    // one-cycle strobe on a step of a synchronised pin
    function gsec_rise;
        input cur;
        input prev;
        begin
            gsec_rise = cur & ~prev;
        end
    endfunction

    function gsec_fall;
        input cur;
        input prev;
        begin
            gsec_fall = ~cur & prev;
        end
    endfunction

    assign rst_rise = gsec_rise(rst_s, rst_prev_q);
    assign rst_fall = gsec_fall(rst_s, rst_prev_q);
    assign smp_fall = gsec_fall(smp_s, smp_prev_q);
    assign cclk_rise = gsec_rise(cclk_s, cclk_prev_q);

    // ************************************************************
    // software registers
    // ************************************************************
    reg [`GSEC_COL_W-1:0] col_start_q;
    reg [`GSEC_COL_W-1:0] col_last_q;
    reg ds_seen_q;
    reg [`GSEC_CNT_W-1:0] int_cnt_q;
    reg [`GSEC_CNT_W-1:0] int_time_q;
    wire wr_status;

    assign wr_status = reg_wr_in && (reg_addr_in == `GSEC_OFS_STATUS);

    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            col_start_q <= `GSEC_RST_COL_START;
            col_last_q <= `GSEC_RST_COL_LAST;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `GSEC_OFS_COL_START)
                col_start_q <= reg_wdata_in[`GSEC_COL_W-1:0];
            if (reg_addr_in == `GSEC_OFS_COL_LAST)
                col_last_q <= reg_wdata_in[`GSEC_COL_W-1:0];
        end
    end

    // ************************************************************
    // reset drivers and integration window
    // ************************************************************
    // full level has priority so a coincident dual slope pulse cannot lower it
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pixel_reset_full_out <= 1'b0;
            pixel_reset_second_out <= 1'b0;
            integrating_out <= 1'b0;
            ds_seen_q <= 1'b0;
        end
        else
        begin
            pixel_reset_full_out <= rst_s;
            pixel_reset_second_out <= ds_s & ~rst_s;
            if (rst_rise)
                integrating_out <= 1'b0;
            else if (rst_fall)
                integrating_out <= 1'b1;
            // hardware set wins over a write-one clear in the same cycle
            if (ds_s & ~rst_s & integrating_out)
                ds_seen_q <= 1'b1;
            else if (wr_status && reg_wdata_in[`GSEC_ST_DS_SEEN])
                ds_seen_q <= 1'b0;
        end
    end

    // integration length, captured when the next reset ends it
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            int_cnt_q <= {`GSEC_CNT_W{1'b0}};
            int_time_q <= {`GSEC_CNT_W{1'b0}};
        end
        else
        begin
            if (rst_rise)
            begin
                int_time_q <= int_cnt_q;
                int_cnt_q <= {`GSEC_CNT_W{1'b0}};
            end
            // the cycle in which integration starts counts as well
            else if (rst_fall)
                int_cnt_q <= {{(`GSEC_CNT_W-1){1'b0}}, 1'b1};
            else if (integrating_out && int_cnt_q != `GSEC_CNT_MAX)
                int_cnt_q <= int_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // pixel memory: precharge, sample, boost
    // ************************************************************
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            precharge_drive_out <= 1'b0;
            sample_drive_out <= 1'b0;
            memory_boost_high_out <= 1'b0;
            memory_stored_out <= 1'b0;
            readout_ready_out <= 1'b0;
        end
        else
        begin
            precharge_drive_out <= pre_s;
            sample_drive_out <= smp_s;
            memory_boost_high_out <= mem_s;
            if (pre_s)
                memory_stored_out <= 1'b0;
            else if (smp_fall)
                memory_stored_out <= 1'b1;
            // stored data stays readable across the next exposure
            readout_ready_out <= memory_stored_out & mem_s & ~pre_s & ~smp_s;
        end
    end

    // ************************************************************
    // output stages and column scan
    // ************************************************************
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            black_test_en_out <= 1'b0;
            output_stage_active_out <= 1'b0;
            column_addr_out <= `GSEC_RST_COL_START;
            pixel_update_out <= 1'b0;
            end_of_line_out <= 1'b0;
        end
        else
        begin
            black_test_en_out <= blk_s;
            output_stage_active_out <= ~oen_s;
            pixel_update_out <= cclk_rise & ~oen_s;
            end_of_line_out <= 1'b0;
            if (cclk_rise)
            begin
                if (csync_s)
                    column_addr_out <= col_start_q;
                else if (column_addr_out == col_last_q)
                    end_of_line_out <= 1'b1;
                else
                    column_addr_out <= column_addr_out + 1'b1;
            end
        end
    end

    // ************************************************************
    // register read port
    // ************************************************************
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            reg_rdata_out <= 32'h00000000;
        else if (reg_rd_in)
        begin
            reg_rdata_out <= 32'h00000000;
            case (reg_addr_in)
                `GSEC_OFS_COL_START: reg_rdata_out[`GSEC_COL_W-1:0] <= col_start_q;
                `GSEC_OFS_COL_LAST: reg_rdata_out[`GSEC_COL_W-1:0] <= col_last_q;
                `GSEC_OFS_STATUS:
                begin
                    reg_rdata_out[`GSEC_ST_INTEGRATING] <= integrating_out;
                    reg_rdata_out[`GSEC_ST_STORED] <= memory_stored_out;
                    reg_rdata_out[`GSEC_ST_DS_SEEN] <= ds_seen_q;
                    reg_rdata_out[`GSEC_ST_FULL_RESET] <= pixel_reset_full_out;
                    reg_rdata_out[`GSEC_ST_STANDBY] <= ~output_stage_active_out;
                    reg_rdata_out[`GSEC_ST_BLACK] <= black_test_en_out;
                    reg_rdata_out[`GSEC_ST_COL_LSB+`GSEC_COL_W-1:`GSEC_ST_COL_LSB] <= column_addr_out;
                end
                `GSEC_OFS_INT_TIME: reg_rdata_out[`GSEC_CNT_W-1:0] <= int_time_q;
                default: reg_rdata_out <= 32'h00000000;
            endcase
        end
        else
            reg_rdata_out <= 32'h00000000;
    end
endmodule

// ### verif/gsec_top_properties.sv
// port-level assertions for the exposure control block
`timescale 1ns/1ps
module gsec_top_props (
    input wire clk_in,
    input wire rstn_in,
    input wire reset_pulse_in,
    input wire dual_slope_reset_pulse_in,
    input wire precharge_in,
    input wire sample_in,
    input wire memory_level_select_in,
    input wire output_enable_n_in,
    input wire column_shift_clk_in,
    input wire pixel_reset_full_out,
    input wire pixel_reset_second_out,
    input wire integrating_out,
    input wire precharge_drive_out,
    input wire sample_drive_out,
    input wire memory_boost_high_out,
    input wire memory_stored_out,
    input wire readout_ready_out,
    input wire output_stage_active_out,
    input wire pixel_update_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rstn_in);
property p_full; reset_pulse_in |-> ##3 pixel_reset_full_out; endproperty
a_full: assert property (p_full) else $error("full reset missing");
property p_integ; $fell(reset_pulse_in) |-> ##3 integrating_out; endproperty
a_integ: assert property (p_integ) else $error("integration not started");
property p_prio; pixel_reset_full_out |-> !pixel_reset_second_out; endproperty
a_prio: assert property (p_prio) else $error("second reset beside full");
property p_ds; dual_slope_reset_pulse_in && !reset_pulse_in |-> ##3 pixel_reset_second_out; endproperty
a_ds: assert property (p_ds) else $error("second reset missing");
property p_boost; $changed(memory_level_select_in) |-> ##3 memory_boost_high_out == $past(memory_level_select_in, 3); endproperty
a_boost: assert property (p_boost) else $error("boost level wrong");
property p_oe; $changed(output_enable_n_in) |-> ##3 output_stage_active_out != $past(output_enable_n_in, 3); endproperty
a_oe: assert property (p_oe) else $error("output stage state wrong");
property p_ready; !memory_level_select_in [*2] |-> ##3 !readout_ready_out; endproperty
a_ready: assert property (p_ready) else $error("readout allowed early");
property p_store; $fell(sample_in) |-> ##[3:4] memory_stored_out; endproperty
a_store: assert property (p_store) else $error("sample not stored");
property p_pre; $changed(precharge_in) |-> ##3 precharge_drive_out == $past(precharge_in, 3); endproperty
a_pre: assert property (p_pre) else $error("precharge drive wrong");
property p_smp; $changed(sample_in) |-> ##3 sample_drive_out == $past(sample_in, 3); endproperty
a_smp: assert property (p_smp) else $error("sample drive wrong");
property p_upd; $rose(column_shift_clk_in) && output_stage_active_out |-> ##3 pixel_update_out ##1 !pixel_update_out;
endproperty
a_upd: assert property (p_upd) else $error("pixel update wrong");
c_second: cover property (pixel_reset_second_out);
c_ready: cover property ($rose(readout_ready_out));
c_upd: cover property (pixel_update_out);
endmodule
bind gsec_top gsec_top_props u_gsec_top_props (.clk_in, .rstn_in, .reset_pulse_in, .dual_slope_reset_pulse_in,
    .precharge_in, .sample_in, .memory_level_select_in, .output_enable_n_in, .column_shift_clk_in,
    .pixel_reset_full_out, .pixel_reset_second_out, .integrating_out, .precharge_drive_out, .sample_drive_out,
    .memory_boost_high_out,
    .memory_stored_out, .readout_ready_out, .output_stage_active_out, .pixel_update_out);

// ### verif/gsec_ctrl_model.sv
// camera controller model: one frame of pixel timing pulses per go
`timescale 1ns/1ps
module gsec_ctrl_model #(
    parameter RW = 6
) (
    input wire clk_in,
    input wire rstn_in,
    input wire go_in,
    input wire [1:0] ds_mode_in,
    output reg reset_pulse_out,
    output reg dual_slope_reset_pulse_out,
    output reg precharge_out,
    output reg sample_out,
    output reg memory_level_select_out,
    output reg done_out
);
integer n_q;
reg [1:0] mode_q;
always @(posedge clk_in or negedge rstn_in)
begin
    if (!rstn_in)
    begin
        n_q <= 0;
        mode_q <= 2'h0;
        {reset_pulse_out, dual_slope_reset_pulse_out, precharge_out, sample_out, done_out} <= 5'h00;
        memory_level_select_out <= 1'b1;
    end
    else
    begin
        if (go_in)
            mode_q <= ds_mode_in;
        n_q <= go_in ? 1 : (n_q != 0 && n_q < 40 + RW) ? n_q + 1 : 0;
        memory_level_select_out <= !(n_q >= 1 && n_q < 20);
        precharge_out <= n_q >= 4 && n_q < 8;
        sample_out <= n_q >= 10 && n_q < 14;
        // reset fall starts the next integration; RW sets the reset width and also delays the mode 1 dual slope pulse and done
        reset_pulse_out <= n_q >= 22 && n_q < 22 + RW;
        // mode 1: during integration, mode 2: on top of reset
        dual_slope_reset_pulse_out <= mode_q == 2'h1 ? n_q >= 30 + RW && n_q < 34 + RW :
            mode_q == 2'h2 && n_q >= 22 && n_q < 22 + RW - 2;
        done_out <= n_q == 40 + RW;
    end
end
endmodule

// ### verif/gsec_top_tb_top.sv
// self-checking bench for the exposure control block
`timescale 1ns/1ps
`include "gsec_map.vh"
module gsec_top_tb_top;
reg clk_in = 0, rstn_in = 0, black_test_in = 0, output_enable_n_in = 1, column_shift_clk_in = 0;
reg column_sync_in = 0, reg_wr_in = 0, reg_rd_in = 0, go = 0, sec, rp_q = 0;
reg [`GSEC_ADDR_W-1:0] reg_addr_in = 4'h0;
reg [31:0] reg_wdata_in = 32'h0;
reg [1:0] ds_mode = 2'h0;
wire reset_pulse_in, dual_slope_reset_pulse_in, precharge_in, sample_in, memory_level_select_in, done;
wire [31:0] reg_rdata_out;
wire [`GSEC_COL_W-1:0] column_addr_out;
wire pixel_reset_full_out, pixel_reset_second_out, integrating_out, precharge_drive_out, sample_drive_out;
wire memory_boost_high_out, memory_stored_out, readout_ready_out, black_test_en_out, output_stage_active_out;
wire pixel_update_out, end_of_line_out;
integer err_total = 0, checks_done = 0, i, n, upd = 0, eol = 0, low_len = 0, int_exp = 0;
gsec_top u_gsec_top (.clk_in, .rstn_in, .reset_pulse_in, .dual_slope_reset_pulse_in, .precharge_in, .sample_in,
    .memory_level_select_in, .black_test_in, .output_enable_n_in, .column_shift_clk_in, .column_sync_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pixel_reset_full_out,
    .pixel_reset_second_out, .integrating_out, .precharge_drive_out, .sample_drive_out, .memory_boost_high_out,
    .memory_stored_out, .readout_ready_out, .black_test_en_out, .output_stage_active_out, .column_addr_out,
    .pixel_update_out, .end_of_line_out);
gsec_ctrl_model u_gsec_ctrl_model (.clk_in, .rstn_in, .go_in(go), .ds_mode_in(ds_mode),
    .reset_pulse_out(reset_pulse_in), .dual_slope_reset_pulse_out(dual_slope_reset_pulse_in),
    .precharge_out(precharge_in), .sample_out(sample_in), .memory_level_select_out(memory_level_select_in),
    .done_out(done));
initial forever #10 clk_in = ~clk_in;
// reference integration length: cycles the reset pin stayed low before its last rise
always @(posedge clk_in)
begin
    rp_q <= reset_pulse_in;
    if (reset_pulse_in && !rp_q)
        int_exp <= low_len;
    if (reset_pulse_in)
        low_len <= 0;
    else if (rp_q || low_len > 0)
        low_len <= low_len + 1;
end
task chk(input [31:0] got, input [31:0] exp);
begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
        err_total = err_total + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
task end_of_test;
begin
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
end
endtask
task wr(input [3:0] a, input [31:0] d);
begin
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
end
endtask
task rd(input [3:0] a, input [31:0] e);
begin
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
    @(posedge clk_in);
end
endtask
task tick(input integer k);
begin
    repeat (k)
    begin
        @(posedge clk_in);
        #1 upd = upd + pixel_update_out;
        eol = eol + end_of_line_out;
        sec = sec | pixel_reset_second_out;
    end
end
endtask
task t_frame(input [1:0] m);
begin
    wr(`GSEC_OFS_STATUS, 32'h4);
    ds_mode <= m;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    sec = 0;
    for (n = 0; n < 200 && done !== 1'b1; n++)
        tick(1);
    if (n == 200)
    begin
        chk(0, 1);
        end_of_test;
    end
    tick(6);
    chk(sec, m == 2'h1);
    chk({integrating_out, memory_stored_out, readout_ready_out}, 3'h7);
    rd(`GSEC_OFS_STATUS, {m == 2'h1, 2'h3} | 32'h10);
    rd(`GSEC_OFS_INT_TIME, int_exp);
    $display("frame test mode %0d done", m);
end
endtask
task t_out;
begin
    for (i = 0; i < 2; i++)
    begin
        black_test_in <= ~i[0];
        output_enable_n_in <= ~i[0];
        tick(4);
        chk({black_test_en_out, output_stage_active_out}, {~i[0], i[0]});
        rd(`GSEC_OFS_STATUS, i ? 32'h3 : 32'h33);
    end
    $display("output stage test done");
end
endtask
task t_col;
begin
    rd(`GSEC_OFS_COL_LAST, 32'(`GSEC_RST_COL_LAST));
    rd(4'h2, 32'h0);
    wr(4'h2, 32'hFF);
    rd(4'h2, 32'h0);
    wr(`GSEC_OFS_COL_START, 32'h5);
    wr(`GSEC_OFS_COL_LAST, 32'h7);
    upd = 0;
    eol = 0;
    column_sync_in <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
        column_shift_clk_in <= 1'b1;
        tick(4);
        column_sync_in <= 1'b0;
        column_shift_clk_in <= 1'b0;
        tick(4);
    end
    chk(upd, 4);
    chk(eol, 32'h1);
    chk(column_addr_out, 7'h07);
    $display("column test done");
end
endtask
initial
begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    for (i = 0; i < 3; i++)
        t_frame(i[1:0]);
    t_out;
    t_col;
    end_of_test;
end
endmodule
